// [rtl/ffmd_axis_cmp.sv]
/*
 * One axis comparator: magnitude against the threshold, high/low and polarity.
 * Assumes a signed sample and an unsigned threshold; purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none
module ffmd_axis_cmp #(
    parameter int SAMPLE_W = 8,
    parameter int THS_W    = 7
) (
    input  wire logic [SAMPLE_W-1:0] sample,
    input  wire logic [THS_W-1:0]    threshold,
    input  wire logic                enable,
    output logic                     high,
    output logic                     low,
    output logic                     neg
);
    logic [SAMPLE_W-1:0] magnitude;
    logic                above;

    // most negative code negates back to itself, 0x80, the largest magnitude
    assign magnitude = sample[SAMPLE_W-1] ? (~sample + SAMPLE_W'(1)) : sample;
    assign above     = (sample == {1'b1, {(SAMPLE_W-1){1'b0}}})
                     || (magnitude > SAMPLE_W'(threshold));
    assign high      = enable & above;             // [R5] [R17]
    assign low       = enable & ~above;            // [R4]
    assign neg       = high & sample[SAMPLE_W-1];  // [R18]

endmodule : ffmd_axis_cmp
`default_nettype wire

// [rtl/ffmd_debounce.sv]
/*
 * Debounce counter with saturation, decrement or clear on a false condition.
 * Assumes tick is a one-cycle pulse per output data sample.
 */
`timescale 1ns/1ps
`default_nettype none
module ffmd_debounce #(
    parameter int CNT_W = 8
) (
    input  wire logic             core_clk,
    input  wire logic             srst,
    input  wire logic             tick,
    input  wire logic             cond,
    input  wire logic             clr,
    input  wire logic             clear_mode,
    input  wire logic [CNT_W-1:0] target,
    output logic [CNT_W-1:0]      count,
    output logic [CNT_W-1:0]      next_count
);
    logic [CNT_W-1:0] eff_target;
    logic [CNT_W-1:0] stepped;

    // zero behaves as one so that at least one qualifying sample is needed
    assign eff_target = (target == '0) ? CNT_W'(1) : target;  // [R20]
    assign stepped = cond ? ((count >= eff_target) ? eff_target
                                                   : count + CNT_W'(1))  // [R16] [R19]
                   : (clear_mode ? '0                                     // [R15]
                                 : ((count == '0) ? '0 : count - CNT_W'(1)));
    assign next_count = clr ? '0 : (tick ? stepped : count);

    always_ff @(posedge core_clk) begin
        if (srst) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

endmodule : ffmd_debounce
`default_nettype wire

// [rtl/ffmd_pkg.sv]
/*
 * Shared constants and carriers for the freefall/motion detector.
 * Assumes one sample of all three axes per output data tick, in two's complement,
 * scaled so that one threshold count equals one sample count.
 */
package ffmd_pkg;

    localparam int SAMPLE_W = 8;
    localparam int THS_W    = 7;
    localparam int CNT_W    = 8;
    localparam int NUM_AXES = 3;
    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 32;

    // register indices; byte address is four times the index
    localparam logic [ADDR_W-1:0] IDX_CFG = 8'h15;
    localparam logic [ADDR_W-1:0] IDX_SRC = 8'h16;
    localparam logic [ADDR_W-1:0] IDX_THS = 8'h17;
    localparam logic [ADDR_W-1:0] IDX_CNT = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_CFG = ADDR_W'(IDX_CFG * 4);
    localparam logic [ADDR_W-1:0] ADDR_SRC = ADDR_W'(IDX_SRC * 4);
    localparam logic [ADDR_W-1:0] ADDR_THS = ADDR_W'(IDX_THS * 4);
    localparam logic [ADDR_W-1:0] ADDR_CNT = ADDR_W'(IDX_CNT * 4);

    // configuration fields
    localparam int CFG_LATCH_BIT = 7;
    localparam int CFG_SEL_BIT   = 6;
    localparam int CFG_EN_LSB    = 3;
    // source fields: axis a has its high flag at 2a+1 and polarity at 2a
    localparam int SRC_EA_BIT    = 7;
    // threshold register fields
    localparam int THS_MODE_BIT  = 7;

    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] THS_RST = 8'h00;
    localparam logic [7:0] CNT_RST = 8'h00;

    typedef struct packed {
        logic [NUM_AXES-1:0][SAMPLE_W-1:0] axis;   // index 0 = x, 1 = y, 2 = z
    } ffmd_sample_s;

    typedef struct packed {
        logic                latch;
        logic                or_sel;
        logic [NUM_AXES-1:0] enable;
    } ffmd_cfg_s;

    typedef struct packed {
        logic [NUM_AXES-1:0] high;
        logic [NUM_AXES-1:0] neg;
    } ffmd_flags_s;

endpackage : ffmd_pkg

// [rtl/ffmd_top.sv]
/*
 * Freefall/motion detector: APB register file, per-axis compare, combine,
 * debounce, event-active flag and per-axis flags, live or latched.
 * Assumes sample_valid pulses once per output data sample with all axes
 * valid in that cycle; APB master follows the usual setup/access sequence.
 */
// What this block does
// R1 - combine select 0 ANDs enabled low conditions, 1 ORs enabled high ones
// R2 - all three axis enables cleared stops detection and clears the counter and an unlatched event flag
// R3 - only axes with their enable set take part in the evaluation
// R4 - freefall: every enabled axis magnitude at or below the threshold
// R5 - motion: any enabled axis magnitude strictly above the threshold
// R6 - event flag sets only once the counter reaches the programmed count
// R7 - unlatched, decrement mode: flag clears after counter decrements back
// R8 - unlatched, clear mode: flag drops with condition, rearms after full delay
// R9 - unlatched source reads have no side effects
// R10 - axis flags follow undebounced high status unless frozen by a latch
// R11 - latched: flag sets at count reached, holds until source read
// R12 - latched source read clears flag, all source bits and counter
// R13 - latched: axis flags freeze on event, resume after a source read
// R14 - config: latch bit7, select bit6, z/y/x enables bits5..3, rest zero
// R15 - decrement mode steps down to zero; clear mode zeroes at once
// R16 - counter saturates at the programmed count
// R17 - axis flags read zero while that axis is disabled
// R18 - polarity flag 0 for positive, 1 for negative acceleration
// R19 - counter advances once per sample while the condition holds
// R20 - a programmed count of zero needs one qualifying sample
`timescale 1ns/1ps
`default_nettype none
module ffmd_top #(
    parameter int CNT_W = ffmd_pkg::CNT_W
) (
    input  wire logic                          core_clk,
    input  wire logic                          srst,
    input  wire logic                          sample_valid,
    input  wire ffmd_pkg::ffmd_sample_s        sample,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [ffmd_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [ffmd_pkg::DATA_W-1:0]   pwdata,
    output logic [ffmd_pkg::DATA_W-1:0]        prdata,
    output logic                               pready,
    output logic                               pslverr,
    output logic                               event_active_flag,
    output ffmd_pkg::ffmd_flags_s              axis_flags
);
    import ffmd_pkg::*;

    // register state
    ffmd_cfg_s           cfg;
    logic                debounce_clear_mode;
    logic [THS_W-1:0]    motion_threshold;
    logic [CNT_W-1:0]    debounce_target_count;
    logic                event_active;
    ffmd_flags_s         flags;

    // bus decode
    logic                setup_phase;
    logic                access_done;
    logic                wr_done;
    logic                rd_done;
    logic                hit_cfg;
    logic                hit_src;
    logic                hit_ths;
    logic                hit_cnt;
    logic                addr_mapped;
    logic [7:0]          cfg_byte;
    logic [7:0]          src_byte;
    logic [7:0]          ths_byte;
    logic [DATA_W-1:0]   next_prdata;
    logic                src_read;
    logic                latch_clear;

    // detection
    logic [NUM_AXES-1:0] axis_high;
    logic [NUM_AXES-1:0] axis_low;
    logic [NUM_AXES-1:0] axis_neg;
    logic                any_enabled;
    logic                and_cond;
    logic                or_cond;
    logic                cond;
    logic [CNT_W-1:0]    dbc_next;
    logic [CNT_W-1:0]    eff_target;
    logic                reach;
    logic                next_event_active;
    ffmd_flags_s         live_flags;
    ffmd_flags_s         next_flags;
    logic                frozen;

    // the slave answers one cycle after setup, so setup always sees pready low
    assign setup_phase = psel & ~penable;
    assign access_done = psel & penable & pready;
    assign wr_done     = access_done & pwrite;
    assign rd_done     = access_done & ~pwrite;

    assign hit_cfg     = (paddr == ADDR_CFG);
    assign hit_src     = (paddr == ADDR_SRC);
    assign hit_ths     = (paddr == ADDR_THS);
    assign hit_cnt     = (paddr == ADDR_CNT);
    assign addr_mapped = hit_cfg | hit_src | hit_ths | hit_cnt;

    assign cfg_byte = {cfg.latch, cfg.or_sel, cfg.enable, 3'b000};  // [R14]
    // disabled axes read zero even when their flags were frozen
    assign src_byte = {event_active, 1'b0,
                       flags.high[2] & cfg.enable[2], flags.neg[2] & cfg.enable[2],
                       flags.high[1] & cfg.enable[1], flags.neg[1] & cfg.enable[1],
                       flags.high[0] & cfg.enable[0], flags.neg[0] & cfg.enable[0]}; // [R17]
    assign ths_byte = {debounce_clear_mode, motion_threshold};

    assign next_prdata = hit_cfg ? {24'h000000, cfg_byte}
                       : hit_src ? {24'h000000, src_byte}
                       : hit_ths ? {24'h000000, ths_byte}
                       : hit_cnt ? {{(DATA_W-CNT_W){1'b0}}, debounce_target_count}
                       : '0;

    // only a completed read of the source register has an effect, and only when latching
    assign src_read    = rd_done & hit_src;
    assign latch_clear = src_read & cfg.latch;  // [R9] [R12]

    always_ff @(posedge core_clk) begin
        if (srst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= setup_phase;
            pslverr <= setup_phase & ~addr_mapped;
            prdata  <= setup_phase ? next_prdata : prdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            cfg <= ffmd_cfg_s'(CFG_RST[7:3]);
        end else if (wr_done && hit_cfg) begin
            cfg.latch  <= pwdata[CFG_LATCH_BIT];                        // [R14]
            cfg.or_sel <= pwdata[CFG_SEL_BIT];
            cfg.enable <= pwdata[CFG_EN_LSB +: NUM_AXES];
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            debounce_clear_mode <= THS_RST[THS_MODE_BIT];
            motion_threshold    <= THS_RST[THS_W-1:0];
        end else if (wr_done && hit_ths) begin
            debounce_clear_mode <= pwdata[THS_MODE_BIT];
            motion_threshold    <= pwdata[THS_W-1:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            debounce_target_count <= CNT_RST[CNT_W-1:0];
        end else if (wr_done && hit_cnt) begin
            debounce_target_count <= pwdata[CNT_W-1:0];
        end
    end

    // per-axis compare
    genvar a;
    generate
        for (a = 0; a < NUM_AXES; a++) begin : g_axis
            ffmd_axis_cmp #(
                .SAMPLE_W (SAMPLE_W),
                .THS_W    (THS_W)
            ) u_cmp (
                .sample    (sample.axis[a]),
                .threshold (motion_threshold),
                .enable    (cfg.enable[a]),                             // [R3]
                .high      (axis_high[a]),
                .low       (axis_low[a]),
                .neg       (axis_neg[a])
            );
        end
    endgenerate

    assign any_enabled = |cfg.enable;                                   // [R2]
    // disabled axes count as satisfied in the AND so only enabled ones decide
    assign and_cond    = any_enabled & (&(axis_low | ~cfg.enable));     // [R3] [R4]
    assign or_cond     = |axis_high;                                    // [R5]
    assign cond        = cfg.or_sel ? or_cond : and_cond;               // [R1]

    ffmd_debounce #(
        .CNT_W (CNT_W)
    ) u_debounce (
        .core_clk   (core_clk),
        .srst       (srst),
        .tick       (sample_valid),                                     // [R19]
        .cond       (cond),
        .clr        (latch_clear | ~any_enabled),                       // [R12] [R2]
        .clear_mode (debounce_clear_mode),                              // [R15]
        .target     (debounce_target_count),
        .count      (),
        .next_count (dbc_next)
    );

    assign eff_target = (debounce_target_count == '0) ? CNT_W'(1)
                                                      : debounce_target_count;  // [R20]
    assign reach      = sample_valid & cond & (dbc_next == eff_target);         // [R6]

    // unlatched, the flag falls when the counter is back at zero: after the full
    // decrement in one mode, at once in the other since the counter clears
    always_comb begin
        next_event_active = event_active;
        if (!any_enabled && !cfg.latch) begin
            next_event_active = 1'b0;                                   // [R2]
        end else if (latch_clear) begin
            next_event_active = 1'b0;                                   // [R12]
        end else if (reach) begin
            next_event_active = 1'b1;                                   // [R6] [R11]
        end else if (!cfg.latch && dbc_next == '0) begin
            next_event_active = 1'b0;                                   // [R7] [R8]
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            event_active <= 1'b0;
        end else begin
            event_active <= next_event_active;
        end
    end

    assign live_flags.high = axis_high;                                 // [R10]
    assign live_flags.neg  = axis_neg;                                  // [R18]
    assign frozen          = cfg.latch & event_active;                  // [R13]

    always_comb begin
        next_flags = flags;
        if (latch_clear) begin
            next_flags = '0;                                            // [R12] [R13]
        end else if (sample_valid && !frozen) begin
            next_flags = live_flags;                                    // [R10]
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            flags <= '0;
        end else begin
            flags <= next_flags;
        end
    end

    // pin copies of the source state, one cycle behind the internal flops
    always_ff @(posedge core_clk) begin
        if (srst) begin
            event_active_flag <= 1'b0;
            axis_flags        <= '0;
        end else begin
            event_active_flag <= event_active;
            axis_flags.high   <= flags.high & cfg.enable;               // [R17]
            axis_flags.neg    <= flags.neg & cfg.enable;
        end
    end

endmodule : ffmd_top
`default_nettype wire

// [verification/ffmd_checker.sv]
/*
 * Port-level assertions for the freefall/motion detector, bound into ffmd_top.
 * Assumes configuration is never rewritten within two cycles of a sample.
 */
`timescale 1ns/1ps
`default_nettype none
module ffmd_checker #(
    parameter int CNT_W = ffmd_pkg::CNT_W
) (
    input wire logic                        core_clk,
    input wire logic                        srst,
    input wire logic                        sample_valid,
    input wire ffmd_pkg::ffmd_sample_s      sample,
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pwrite,
    input wire logic [ffmd_pkg::ADDR_W-1:0] paddr,
    input wire logic [ffmd_pkg::DATA_W-1:0] pwdata,
    input wire logic [ffmd_pkg::DATA_W-1:0] prdata,
    input wire logic                        pready,
    input wire logic                        pslverr,
    input wire logic                        event_active_flag,
    input wire ffmd_pkg::ffmd_flags_s       axis_flags
);
    import ffmd_pkg::*;
    logic [7:0] cfg_q;
    logic [7:0] ths_q;
    logic [2:0] hi;
    wire        done   = psel && penable && pready;
    wire        rd_src = done && !pwrite && paddr == ADDR_SRC;
    wire        mapped = paddr inside {ADDR_CFG, ADDR_SRC, ADDR_THS, ADDR_CNT};
    wire        latch  = cfg_q[7];
    wire [2:0]  en     = cfg_q[5:3];
    wire [2:0]  hi_en  = hi & en;
    wire [2:0]  neg_en = hi_en & {sample.axis[2][7], sample.axis[1][7], sample.axis[0][7]};
    // freefall with no axis enabled must stay idle, not read as an empty AND
    wire        cond   = cfg_q[6] ? |hi_en : (en != 3'h0 && hi_en == 3'h0);

    function automatic logic above(logic [7:0] s, logic [6:0] t);
        // -128 has magnitude 0x80, above any 7-bit threshold
        return (s[7] ? 8'(8'h00 - s) : s) > {1'b0, t};
    endfunction : above

    always_comb begin
        for (int a = 0; a < 3; a++) begin
            hi[a] = above(sample.axis[a], ths_q[6:0]);
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            cfg_q <= 8'h00;
            ths_q <= 8'h00;
        end else if (done && pwrite) begin
            cfg_q <= (paddr == ADDR_CFG) ? pwdata[7:0] : cfg_q;
            ths_q <= (paddr == ADDR_THS) ? pwdata[7:0] : ths_q;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_latched_read;
        rd_src && latch ##1 !sample_valid;
    endsequence
    sequence s_clear_drop;
        sample_valid && !latch && ths_q[7] && !cond ##1 !sample_valid;
    endsequence

    a_access_single: assert property (s_setup |=> pready ##1 !pready)
        else $error("pready is not a single access cycle");
    a_unmapped_error: assert property (s_setup |=> pslverr == !$past(mapped))
        else $error("pslverr does not match address decode");
    a_polarity_high: assert property ((axis_flags.neg & ~axis_flags.high) == 3'h0)
        else $error("polarity flag without high flag");
    a_disabled_axis_zero: assert property (en == $past(en) |->
        ((axis_flags.high | axis_flags.neg) & ~en) == 3'h0)
        else $error("flag set on a disabled axis");
    a_live_flags: assert property (sample_valid && !latch |-> ##2
        axis_flags.high == $past(hi_en, 2) && axis_flags.neg == $past(neg_en, 2))
        else $error("axis flags do not follow the sample");
    a_event_from_sample: assert property ($rose(event_active_flag) |-> $past(sample_valid, 2))
        else $error("event flag rose without a sample");
    a_latched_hold: assert property (event_active_flag && latch && $past(latch) &&
        !rd_src && !$past(rd_src) |=> event_active_flag)
        else $error("latched event dropped without a read");
    a_latched_clear: assert property (s_latched_read |-> ##1
        (!event_active_flag && axis_flags == 6'h00))
        else $error("latched read did not clear the source");
    a_clear_mode_drop: assert property (s_clear_drop |-> ##1 !event_active_flag)
        else $error("event stayed after condition dropped in clear mode");
    a_read_quiet: assert property (rd_src && !latch && !sample_valid |-> ##2
        $stable(event_active_flag) && $stable(axis_flags))
        else $error("unlatched read changed the flags");
endmodule : ffmd_checker

bind ffmd_top ffmd_checker #(.CNT_W(CNT_W)) u_chk (
    .core_clk(core_clk), .srst(srst), .sample_valid(sample_valid), .sample(sample),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .event_active_flag(event_active_flag), .axis_flags(axis_flags)
);
`default_nettype wire

// [verification/ffmd_tb_top.sv]
/*
 * Self-checking bench for the freefall/motion detector: APB tasks, sample pulses
 * and source-register readback. Assumes the checker is bound to ffmd_top.
 */
`timescale 1ns/1ps
`default_nettype none
module ffmd_tb_top;
    import ffmd_pkg::*;
    logic              core_clk;
    logic              srst;
    logic              sample_valid;
    ffmd_sample_s      sample;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    logic              event_active_flag;
    ffmd_flags_s       axis_flags;
    int                mismatches;
    int                checks;

    ffmd_top dut (
        .core_clk(core_clk), .srst(srst), .sample_valid(sample_valid), .sample(sample),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .event_active_flag(event_active_flag), .axis_flags(axis_flags)
    );

    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [32:0] q);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge core_clk);
        penable <= 1'b1;
        // no local limit: only the watchdog may end a wait for pready
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        q = {pslverr, prdata};
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [32:0] q;
        apb(1'b1, a, d, q);
    endtask : wr

    // expected value carries pslverr in bit 32
    task automatic rd(input logic [7:0] a, input logic [32:0] e, input string name);
        logic [32:0] q;
        apb(1'b0, a, 8'h00, q);
        checks++;
        if (q !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, e, q);
        end
    endtask : rd

    task automatic smp(input logic [7:0] x, input logic [7:0] y, input logic [7:0] z);
        sample       <= {z, y, x};
        sample_valid <= 1'b1;
        @(posedge core_clk);
        sample_valid <= 1'b0;
        @(posedge core_clk);
    endtask : smp

    task automatic test_done();
        if (mismatches == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done

    initial begin
        core_clk = 1'b0;
        forever begin
            #25 core_clk = ~core_clk;
        end
    end

    initial begin
        repeat (5000) @(posedge core_clk);
        mismatches++;
        test_done();
    end

    initial begin
        mismatches = 0;
        checks = 0;
        srst = 1'b1;
        sample_valid = 1'b0;
        sample = '0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        repeat (12) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        rd(ADDR_CFG, 33'h000, "cfg");
        rd(ADDR_THS, 33'h000, "ths");
        rd(ADDR_CNT, 33'h000, "cnt");
        rd(ADDR_SRC, 33'h000, "src");
        wr(ADDR_CFG, 8'hFF);
        rd(ADDR_CFG, 33'h0F8, "cfg");
        rd(8'h00, 33'h100000000, "unmapped");
        // motion on x only, decrement mode, two-sample debounce
        wr(ADDR_CFG, 8'h48);
        wr(ADDR_THS, 8'h14);
        wr(ADDR_CNT, 8'h02);
        smp(8'h15, 8'h64, 8'h00);
        rd(ADDR_SRC, 33'h002, "src");
        smp(8'hEB, 8'h00, 8'h00);
        rd(ADDR_SRC, 33'h083, "src");
        rd(ADDR_SRC, 33'h083, "src");
        smp(8'hEB, 8'h00, 8'h00);
        smp(8'h14, 8'h00, 8'h00);
        rd(ADDR_SRC, 33'h080, "src");
        smp(8'h00, 8'h00, 8'h00);
        rd(ADDR_SRC, 33'h000, "src");
        // clear mode
        wr(ADDR_THS, 8'h94);
        smp(8'h15, 8'h00, 8'h00);
        smp(8'h15, 8'h00, 8'h00);
        rd(ADDR_SRC, 33'h082, "src");
        smp(8'h00, 8'h00, 8'h00);
        rd(ADDR_SRC, 33'h000, "src");
        smp(8'h15, 8'h00, 8'h00);
        rd(ADDR_SRC, 33'h002, "src");
        // freefall, count of zero
        wr(ADDR_CNT, 8'h00);
        wr(ADDR_CFG, 8'h38);
        smp(8'h14, 8'hEC, 8'h05);
        rd(ADDR_SRC, 33'h080, "src");
        smp(8'h15, 8'h00, 8'h00);
        rd(ADDR_SRC, 33'h002, "src");
        wr(ADDR_CFG, 8'h30);
        smp(8'h80, 8'h00, 8'h00);
        rd(ADDR_SRC, 33'h080, "src");
        wr(ADDR_CFG, 8'h00);
        smp(8'h00, 8'h00, 8'h00);
        rd(ADDR_SRC, 33'h000, "src");
        // latched motion on x
        wr(ADDR_THS, 8'h14);
        wr(ADDR_CNT, 8'h02);
        wr(ADDR_CFG, 8'hC8);
        smp(8'h15, 8'h00, 8'h00);
        smp(8'h15, 8'h00, 8'h00);
        smp(8'hE2, 8'h00, 8'h00);
        rd(ADDR_SRC, 33'h082, "src");
        rd(ADDR_SRC, 33'h000, "src");
        smp(8'hE2, 8'h00, 8'h00);
        rd(ADDR_SRC, 33'h003, "src");
        smp(8'hE2, 8'h00, 8'h00);
        smp(8'hE2, 8'h00, 8'h00);
        rd(ADDR_SRC, 33'h083, "src");
        test_done();
    end
endmodule : ffmd_tb_top
`default_nettype wire
